//--- verilog/sdc_pkg.sv
// Purpose: constants for the SDRAM init, timing and self-refresh controller
// Assumes: 10 MHz clock, cycle counts taken from the slow speed grade values
// Notes: times in ns, cycle counts derived (min rounds up)
package sdc_pkg;
    localparam int sdc_clk_ns = 100;
    localparam int sdc_trc_ns_f = 60;
    localparam int sdc_trc_ns_s = 70;
    localparam int sdc_trrd_ns_f = 12;
    localparam int sdc_trrd_ns_s = 14;
    localparam int sdc_trcd_ns_f = 18;
    localparam int sdc_trcd_ns_s = 20;
    localparam int sdc_trp_ns_f = 18;
    localparam int sdc_trp_ns_s = 20;
    localparam int sdc_tras_ns_f = 42;
    localparam int sdc_tras_ns_s = 45;
    localparam int sdc_tras_max_ns = 120000;
    localparam int sdc_tccd_clk = 1;
    localparam int sdc_tmrs_clk = 2;
    localparam int sdc_twr_clk = 2;
    localparam int sdc_pause_us = 200;
    localparam int sdc_refi_ns = 15600;
    localparam int sdc_init_refs = 2;
    localparam int sdc_burst_refs = 2048;
    localparam int sdc_banks = 4;
    function automatic int sdc_up(input int ns);
        int c;
        c = (ns + sdc_clk_ns - 1) / sdc_clk_ns;
        return (c < 1) ? 1 : c;
    endfunction
    function automatic int sdc_dn(input int ns);
        int c;
        c = ns / sdc_clk_ns;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int sdc_trc_clk = sdc_up(sdc_trc_ns_s);
    localparam int sdc_trrd_clk = sdc_up(sdc_trrd_ns_s);
    localparam int sdc_trcd_clk = sdc_up(sdc_trcd_ns_s);
    localparam int sdc_trp_clk = sdc_up(sdc_trp_ns_s);
    localparam int sdc_tras_clk = sdc_up(sdc_tras_ns_s);
    localparam int sdc_tras_max_clk = sdc_dn(sdc_tras_max_ns);
    localparam int sdc_pause_clk = sdc_up(sdc_pause_us * 1000);
    localparam int sdc_refi_clk = sdc_dn(sdc_refi_ns);
    // Command encodings {cs_b, ras_b, cas_b, we_b}
    localparam logic [3:0] sdc_cmd_nop = 4'h7;
    localparam logic [3:0] sdc_cmd_act = 4'h3;
    localparam logic [3:0] sdc_cmd_rd = 4'h5;
    localparam logic [3:0] sdc_cmd_wr = 4'h4;
    localparam logic [3:0] sdc_cmd_pre = 4'h2;
    localparam logic [3:0] sdc_cmd_ref = 4'h1;
    localparam logic [3:0] sdc_cmd_mrs = 4'h0;
    localparam logic [3:0] sdc_cmd_desel = 4'hf;
    localparam int sdc_a10 = 10;
    localparam logic [11:0] sdc_mode_dflt = 12'h022;
    typedef enum logic [3:0] {
        sdc_pwr, sdc_ipre, sdc_imrs, sdc_iref, sdc_idle, sdc_actv,
        sdc_rdwr, sdc_prech, sdc_aref, sdc_sr_pre, sdc_sr_in,
        sdc_sr_out, sdc_sr_post
    } sdc_state_t;
endpackage

//--- verilog/sdc_ctrl.sv
// Purpose: SDRAM controller: power-up init, command spacing, refresh,
//          self-refresh entry and exit, single-word read and write
// Assumes: one clock at 10 MHz drives both this block and the memory clock
// Notes: a user request is taken on req & ready, one word at a time
`timescale 1ns/1ns
// Operation
// RQ1 - Same-bank activations spaced by at least the row cycle time.
// RQ2 - Activations of different banks spaced by at least activate delay.
// RQ3 - Read or write waits activate-to-column delay after activation.
// RQ4 - Refresh or activate waits precharge time after precharge.
// RQ5 - Row stays open between minimum and maximum active time.
// RQ6 - Column commands may follow every single clock.
// RQ7 - Mode register set cycle time elapses before next command.
// RQ8 - During power-up hold NOP, clock enable high, masks high.
// RQ9 - Wait 200 microseconds after power before initialisation.
// RQ10 - Keep masks high through the power-up pause.
// RQ11 - Precharge all banks during initialisation.
// RQ12 - Issue mode register set during initialisation.
// RQ13 - Issue at least two auto-refresh cycles during initialisation.
// RQ14 - Self-refresh entry: select, row, column strobes and CKE low.
// RQ15 - Device ignores all inputs but CKE one clock after entry.
// RQ16 - Device stays in self-refresh while CKE stays low.
// RQ17 - Stay in self-refresh at least the minimum row active time.
// RQ18 - Clock runs stable before CKE returns high.
// RQ19 - Hold CKE high for exit time with chip deselected first.
// RQ20 - Wait one row cycle after CKE high before commands.
// RQ21 - Burst refresh 2048 cycles before entry and after exit.
// RQ22 - Masks gate write data and enable read output buffers.
// RQ23 - Wait two clocks write recovery before precharge.
// RQ24 - Refresh on average every 15.6 microseconds.
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int pause_clk = sdc_pause_clk,
    parameter int refi_clk = sdc_refi_clk,
    parameter int burst_refs = sdc_burst_refs,
    parameter int row_w = 12,
    parameter int col_w = 9
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // User side
    input wire logic req,
    input wire logic req_wr,
    input wire logic [1:0] req_bank,
    input wire logic [row_w-1:0] req_row,
    input wire logic [col_w-1:0] req_col,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_mask,
    input wire logic sr_req,
    output logic ready,
    output logic rvalid,
    output logic [31:0] rdata,
    output logic init_done,
    output logic in_sr,
    // Memory pins
    output logic mem_cke,
    output logic mem_cs_b,
    output logic mem_ras_b,
    output logic mem_cas_b,
    output logic mem_we_b,
    output logic [1:0] mem_ba,
    output logic [11:0] mem_addr,
    output logic [3:0] mem_dqm,
    output logic [31:0] mem_dq_out,
    output logic mem_dq_oe,
    input wire logic [31:0] mem_dq_in
);
    localparam int cas_lat = 2;
    localparam int cw = 18;
    localparam int nw = 12;
    localparam logic [cw-1:0] wait_trc = cw'(sdc_trc_clk);
    localparam logic [cw-1:0] wait_trcd = cw'(sdc_trcd_clk);
    localparam logic [cw-1:0] wait_trp = cw'(sdc_trp_clk);
    localparam logic [cw-1:0] wait_tras = cw'(sdc_tras_clk);
    localparam logic [cw-1:0] wait_tmrs = cw'(sdc_tmrs_clk);
    localparam logic [cw-1:0] wait_twr = cw'(sdc_twr_clk);
    localparam logic [cw-1:0] wait_pause = cw'(pause_clk);
    localparam logic [cw-1:0] wait_refi = cw'(refi_clk);
    localparam logic [nw-1:0] n_burst = nw'(burst_refs);
    localparam logic [nw-1:0] n_init = nw'(sdc_init_refs);

    // Checked at elaboration: counters are only cw and nw bits wide
    if (pause_clk < 1 || pause_clk >= (1 << cw))
        $error("pause_clk out of range");
    if (refi_clk < 8 || refi_clk >= (1 << cw))
        $error("refi_clk out of range");
    if (burst_refs < 1 || burst_refs >= (1 << nw))
        $error("burst_refs out of range");
    if (row_w != 12 || col_w > 10)
        $error("address widths unsupported");

    sdc_state_t state;
    sdc_state_t next_state;
    logic [cw-1:0] wait_cnt;
    logic [cw-1:0] refi_cnt;
    logic [nw-1:0] ref_left;
    logic ref_due;
    logic [3:0] cmd;
    logic [cas_lat:0] rd_pipe;
    logic sr_q1;
    logic sr_q2;
    logic op_wr;
    logic [1:0] op_bank;
    logic [col_w-1:0] op_col;
    logic [31:0] op_data;
    logic [3:0] op_mask;
    logic [1:0] sr_step;

    default clocking sdc_cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Decode of when the current wait has run out
    wire waited = (wait_cnt == '0);
    wire take_req = ready && req;
    wire refi_hit = (refi_cnt == '0);
    wire [nw-1:0] ref_dec = ref_left - nw'(1);

    // Self-refresh request is asynchronous to this clock
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sr_q1 <= 1'b0;
            sr_q2 <= 1'b0;
        end else begin
            sr_q1 <= sr_req;
            sr_q2 <= sr_q1;
        end
    end

    // Periodic refresh timer; set beats clear of the due flag
    always_ff @(posedge clock) begin
        if (!rst_b || state == sdc_pwr) begin
            refi_cnt <= wait_refi;
            ref_due <= 1'b0;
        end else begin
            refi_cnt <= refi_hit ? wait_refi : refi_cnt - cw'(1);
            if (refi_hit)
                ref_due <= 1'b1; // see RQ24
            else if (state == sdc_aref && cmd == sdc_cmd_ref)
                ref_due <= 1'b0;
        end
    end

    // Sequencer: one command per state entry except sdc_pwr and sdc_idle, then a wait count; refresh burst states repeat theirs.
    // A single open row keeps RQ1/RQ2 trivially met: every access
    // closes its row, so same-bank activations are trc apart.
    always_comb begin
        next_state = state;
        case (state)
            sdc_pwr:    if (waited && sr_step != 2'h0) next_state = sdc_ipre;
            sdc_ipre:   if (waited) next_state = sdc_imrs;
            sdc_imrs:   if (waited) next_state = sdc_iref;
            sdc_iref:   if (waited && ref_left == '0)
                            next_state = sdc_idle;
            sdc_idle: begin
                // A request granted by ready must not be lost to refresh
                if (!waited)
                    next_state = sdc_idle;
                else if (take_req)
                    next_state = sdc_actv;
                else if (sr_q2)
                    next_state = sdc_sr_pre;
                else if (ref_due)
                    next_state = sdc_aref;
            end
            sdc_actv:   if (waited) next_state = sdc_rdwr;
            sdc_rdwr:   if (waited) next_state = sdc_prech;
            sdc_prech:  if (waited) next_state = sdc_idle;
            sdc_aref:   if (waited) next_state = sdc_idle;
            sdc_sr_pre: if (waited && ref_left == '0)
                            next_state = sdc_sr_in;
            sdc_sr_in:  if (waited && !sr_q2) next_state = sdc_sr_out;
            sdc_sr_out: if (waited) next_state = sdc_sr_post;
            sdc_sr_post: if (waited && ref_left == '0)
                            next_state = sdc_idle;
            default:    next_state = sdc_pwr;
        endcase
    end

    wire ref_step = waited && ref_left != '0;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= sdc_pwr;
            wait_cnt <= '0;
            ref_left <= '0;
            cmd <= sdc_cmd_nop;
            sr_step <= 2'h0;
        end else begin
            state <= next_state;
            cmd <= sdc_cmd_nop;
            wait_cnt <= waited ? '0 : wait_cnt - cw'(1);
            case (next_state)
                sdc_pwr: if (state == sdc_pwr && sr_step == 2'h0) begin
                    wait_cnt <= wait_pause; // see RQ9
                    sr_step <= 2'h1;
                end
                sdc_ipre: if (state != sdc_ipre) begin
                    cmd <= sdc_cmd_pre; // see RQ11
                    wait_cnt <= wait_trp; // see RQ4
                end
                sdc_imrs: if (state != sdc_imrs) begin
                    cmd <= sdc_cmd_mrs; // see RQ12
                    wait_cnt <= wait_tmrs; // see RQ7
                    ref_left <= n_init; // see RQ13
                end
                sdc_iref, sdc_sr_pre, sdc_sr_post:
                    if (state != next_state || ref_step) begin
                        if (ref_left != '0 && waited) begin
                            cmd <= sdc_cmd_ref; // see RQ21
                            ref_left <= ref_dec;
                            wait_cnt <= wait_trc;
                        end
                    end
                sdc_actv: if (state != sdc_actv) begin
                    cmd <= sdc_cmd_act; // see RQ2
                    wait_cnt <= wait_trcd; // see RQ3
                end
                sdc_rdwr: if (state != sdc_rdwr) begin
                    cmd <= op_wr ? sdc_cmd_wr : sdc_cmd_rd;
                    // Row must also meet minimum active time
                    wait_cnt <= (wait_tras > wait_trcd + wait_twr)
                        ? wait_tras - wait_trcd
                        : wait_twr + cw'(cas_lat); // see RQ5 see RQ23
                end
                sdc_prech: if (state != sdc_prech) begin
                    cmd <= sdc_cmd_pre;
                    wait_cnt <= wait_trp; // see RQ4 see RQ1
                end
                sdc_aref: if (state != sdc_aref) begin
                    cmd <= sdc_cmd_ref;
                    wait_cnt <= wait_trc;
                end
                sdc_sr_in: if (state != sdc_sr_in) begin
                    cmd <= sdc_cmd_ref; // see RQ14
                    wait_cnt <= wait_tras; // see RQ17
                end
                sdc_sr_out: if (state != sdc_sr_out) begin
                    cmd <= sdc_cmd_desel; // see RQ19
                    wait_cnt <= wait_trc; // see RQ20
                end
                default: ;
            endcase
            if (state == sdc_sr_in && next_state == sdc_sr_out)
                ref_left <= n_burst;
            if (state == sdc_idle && next_state == sdc_sr_pre)
                ref_left <= n_burst;
        end
    end

    // Capture the request when the row is opened
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            op_wr <= 1'b0;
            op_bank <= 2'h0;
            op_col <= '0;
            op_data <= 32'h0;
            op_mask <= 4'h0;
            ready <= 1'b0;
        end else begin
            ready <= (next_state == sdc_idle) && (state != sdc_idle ||
                !take_req) && !sr_q2 && !ref_due;
            if (take_req) begin
                op_wr <= req_wr;
                op_bank <= req_bank;
                op_col <= req_col;
                op_data <= req_wdata;
                op_mask <= req_mask;
            end
        end
    end

    // Read return after CAS latency; DQM low enables output buffers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_pipe <= '0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
        end else begin
            rd_pipe <= {rd_pipe[cas_lat-1:0],
                state != sdc_rdwr && next_state == sdc_rdwr && !op_wr};
            rvalid <= rd_pipe[cas_lat];
            if (rd_pipe[cas_lat])
                rdata <= mem_dq_in;
        end
    end

    wire wr_issue = state != sdc_rdwr && next_state == sdc_rdwr && op_wr;
    wire sr_hold = next_state == sdc_sr_in;
    wire pwr_hold = next_state == sdc_pwr;

    // Pin registers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mem_cke <= 1'b1; // see RQ8
            mem_dqm <= 4'hf; // see RQ10
            mem_dq_oe <= 1'b0;
            mem_dq_out <= 32'h0;
            mem_ba <= 2'h0;
            mem_addr <= 12'h0;
            init_done <= 1'b0;
            in_sr <= 1'b0;
        end else begin
            // Clock keeps running, so it is stable before CKE rises
            mem_cke <= !sr_hold; // see RQ14 see RQ16 see RQ18
            mem_dqm <= wr_issue ? op_mask // see RQ22
                : (pwr_hold ? 4'hf : 4'h0);
            mem_dq_oe <= wr_issue;
            mem_dq_out <= op_data;
            mem_ba <= take_req ? req_bank : op_bank;
            if (take_req)
                mem_addr <= req_row;
            else if (next_state == sdc_imrs)
                mem_addr <= sdc_mode_dflt;
            else if (next_state == sdc_ipre || next_state == sdc_prech)
                mem_addr <= 12'h1 << sdc_a10;
            else
                mem_addr <= 12'(op_col);
            init_done <= init_done || next_state == sdc_idle;
            in_sr <= sr_hold; // see RQ15
        end
    end

    wire [3:0] next_cmd = cmd;
    assign {mem_cs_b, mem_ras_b, mem_cas_b, mem_we_b} = next_cmd; // see RQ6

    mrs_gap_a: assert property (cmd == sdc_cmd_mrs |=> // see RQ7
        (cmd == sdc_cmd_nop) [*2])
        else $error("command too soon after mode set");
    sr_cke_a: assert property ($fell(mem_cke) |-> // see RQ14
        cmd == sdc_cmd_ref)
        else $error("CKE fell without refresh command");
    pwr_nop_a: assert property (state == sdc_pwr |-> // see RQ8
        cmd == sdc_cmd_nop && mem_dqm == 4'hf)
        else $error("power-up not idle");
    act_rw_a: assert property (cmd == sdc_cmd_act |=> // see RQ3
        cmd == sdc_cmd_nop)
        else $error("column too soon after activate");
    pre_gap_a: assert property (cmd == sdc_cmd_pre |=> // see RQ4
        cmd != sdc_cmd_act && cmd != sdc_cmd_ref)
        else $error("precharge time violated");
    sr_min_a: assert property ($fell(mem_cke) |=> !mem_cke) // see RQ17
        else $error("self-refresh too short");
    exit_cs_a: assert property ($rose(mem_cke) |-> mem_cs_b) // see RQ19
        else $error("chip selected on self-refresh exit");
    wr_oe_a: assert property (mem_dq_oe |-> cmd == sdc_cmd_wr) // see RQ22
        else $error("data driven outside write");
endmodule

//--- verif/sdc_mem.sv
// Purpose: behavioural memory device model that watches controller timing
// Assumes: single-word accesses, CAS latency 2, clock never stops
// Notes: slips are counted in n_bad; an undriven data bus shows inverted bits
`timescale 1ns/1ns
module sdc_mem
    import sdc_pkg::*;
#(
    parameter int pause_clk = 40,
    parameter int refi_clk = 60,
    parameter int burst_refs = 4
) (
    // Memory pins
    input wire logic clock,
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic [1:0] ba,
    input wire logic [11:0] addr,
    input wire logic [3:0] dqm,
    input wire logic [31:0] dq,
    output logic [31:0] dq_drv,
    // Status
    output logic sr,
    output int n_bad
);
    logic [31:0] mem [logic [22:0]];
    logic [11:0] row [4];
    logic open [4];
    int ta [4], tp [4], tw [4];
    int cyc, tany, tm, tr, tx, ts, ini, nref, brun, post;
    logic [3:0] cmd, m1, m2;
    logic [31:0] d1, d2, mk;
    logic v1, v2, up;
    logic [22:0] k;

    function automatic void bad(input logic c);
        if (c) n_bad = n_bad + 1;
    endfunction

    initial begin
        n_bad = 0; sr = 0; up = 0; v1 = 0; dq_drv = 32'h5a5aa5a5;
        cyc = 0; tany = -999; tm = -999; tr = -999; tx = -999;
        ini = 0; nref = 0; brun = 0; post = 0;
        foreach (ta[b]) begin
            ta[b] = -999; tp[b] = -999; tw[b] = -999; open[b] = 0;
        end
    end

    always @(posedge clock) begin
        cmd = cs_b ? sdc_cmd_nop : {1'b0, ras_b, cas_b, we_b};
        k = {ba, row[ba], addr[8:0]};
        v2 = v1; d2 = d1; m2 = m1; v1 = 1'b0;
        if (cke === 1'b1) up = 1'b1;
        if (up) cyc++;
        if (up && sr) begin
            // Only the clock enable is watched here, plus chip select on the exit cycle
            if (cke === 1'b1) begin
                bad(cyc - ts < sdc_tras_clk);
                bad(cs_b !== 1'b1);
                sr = 0; tx = cyc; tr = cyc; post = burst_refs;
            end
        end else if (up && cmd == sdc_cmd_ref && cke !== 1'b1) begin
            bad(brun < burst_refs || ini < 3);
            sr = 1; ts = cyc;
        end else if (up && cmd != sdc_cmd_nop) begin
            bad(cyc < pause_clk);
            bad(cyc - tm < sdc_tmrs_clk);
            bad(cyc - tx < sdc_trc_clk);
            bad(post > 0 && cmd != sdc_cmd_ref);
            bad(ini < 3 && cmd[3:2] == 2'b01);
            brun = (cmd == sdc_cmd_ref) ? brun + 1 : 0;
            case (cmd)
                sdc_cmd_act: begin
                    bad(open[ba] || cyc - ta[ba] < sdc_trc_clk);
                    bad(cyc - tany < sdc_trrd_clk);
                    bad(cyc - tp[ba] < sdc_trp_clk);
                    open[ba] = 1; row[ba] = addr; ta[ba] = cyc; tany = cyc;
                end
                sdc_cmd_rd, sdc_cmd_wr: begin
                    bad(!open[ba] || cyc - ta[ba] < sdc_trcd_clk);
                    if (!mem.exists(k)) mem[k] = ~dq_drv;
                    if (cmd == sdc_cmd_wr) begin
                        for (int b = 0; b < 4; b++)
                            if (!dqm[b]) mem[k][8*b+:8] = dq[8*b+:8];
                        tw[ba] = cyc;
                    end else begin
                        v1 = 1; d1 = mem[k]; m1 = dqm;
                    end
                end
                sdc_cmd_pre: begin
                    foreach (ta[b]) if (addr[sdc_a10] || ba == b[1:0]) begin
                        bad(open[b] && cyc - ta[b] < sdc_tras_clk);
                        bad(open[b] && cyc - ta[b] > sdc_tras_max_clk);
                        bad(open[b] && cyc - tw[b] < sdc_twr_clk);
                        open[b] = 0; tp[b] = cyc;
                    end
                    if (addr[sdc_a10] && ini == 0) ini = 1;
                end
                sdc_cmd_ref: begin
                    foreach (tp[b]) bad(open[b] || cyc - tp[b] < sdc_trp_clk);
                    bad(cyc - tr < sdc_trc_clk);
                    if (post > 0) post--;
                    if (ini == 2) nref++;
                    if (ini == 2 && nref >= sdc_init_refs) ini = 3;
                    tr = cyc;
                end
                sdc_cmd_mrs: begin
                    if (ini == 1) ini = 2;
                    tm = cyc;
                end
                default: ;
            endcase
        end
        if (up && ini == 0)
            bad(cke !== 1'b1 || dqm !== 4'hf || cmd != sdc_cmd_nop);
        // Average rate only, so allow twice the interval
        if (up && !sr && ini == 3) bad(cyc - tr > 2 * refi_clk);
        // Masked bytes stay off the bus, as if high impedance
        mk = {{8{m2[3]}}, {8{m2[2]}}, {8{m2[1]}}, {8{m2[0]}}};
        if (v2) begin
            #6 dq_drv = (d2 & ~mk) | (~dq_drv & mk);
        end else begin
            #2 dq_drv = ~dq_drv;
        end
    end
endmodule

//--- verif/testbench.sv
// Purpose: self-checking bench for the memory controller
// Assumes: device model on the memory pins, shortened pause and refresh
// Notes: read results are matched in order through a queue
`timescale 1ns/1ns
module testbench
    import sdc_pkg::*;
;
    localparam int pause = 40;
    localparam int refi = 60;
    localparam int brefs = 4;
    logic clock, rst_b, req, req_wr, sr_req, ready, rvalid, init_done;
    logic in_sr, mem_cke, mem_cs_b, mem_ras_b, mem_cas_b, mem_we_b;
    logic mem_dq_oe, dev_sr;
    logic [1:0] req_bank, mem_ba;
    logic [11:0] req_row, mem_addr;
    logic [8:0] req_col;
    logic [3:0] req_mask, mem_dqm;
    logic [31:0] req_wdata, rdata, mem_dq_out, dq_drv, dq, seed;
    logic [31:0] shadow [logic [22:0]];
    logic [31:0] exp_q [$];
    logic [22:0] adr [8];
    int err_count, n_compared, n_bad;

    assign dq = mem_dq_oe ? mem_dq_out : dq_drv;

    sdc_ctrl #(.pause_clk(pause), .refi_clk(refi), .burst_refs(brefs)) dut (
        .clock(clock), .rst_b(rst_b), .req(req), .req_wr(req_wr),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .req_mask(req_mask), .sr_req(sr_req),
        .ready(ready), .rvalid(rvalid), .rdata(rdata),
        .init_done(init_done), .in_sr(in_sr), .mem_cke(mem_cke),
        .mem_cs_b(mem_cs_b), .mem_ras_b(mem_ras_b), .mem_cas_b(mem_cas_b),
        .mem_we_b(mem_we_b), .mem_ba(mem_ba), .mem_addr(mem_addr),
        .mem_dqm(mem_dqm), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
        .mem_dq_in(dq));

    sdc_mem #(.pause_clk(pause), .refi_clk(refi), .burst_refs(brefs)) dev (
        .clock(clock), .cke(mem_cke), .cs_b(mem_cs_b), .ras_b(mem_ras_b),
        .cas_b(mem_cas_b), .we_b(mem_we_b), .ba(mem_ba), .addr(mem_addr),
        .dqm(mem_dqm), .dq(dq), .dq_drv(dq_drv), .sr(dev_sr),
        .n_bad(n_bad));

    // Free-running clock, so it is always stable before exit
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("compared %0d, mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_lvl(ref logic s, input logic v, input string nm);
        int n;
        n = 0;
        while (s !== v && n < 3000) begin
            @(negedge clock);
            n++;
        end
        check(nm, 32'(v), 32'(s));
    endtask

    // Request stays up until a rising edge samples ready high
    task automatic acc(input logic wr, input logic [22:0] a,
                       input logic [31:0] d, input logic [3:0] m);
        int n;
        @(negedge clock);
        req = 1'b1;
        req_wr = wr;
        {req_bank, req_row, req_col} = a;
        req_wdata = d;
        req_mask = m;
        n = 0;
        @(posedge clock);
        while (ready !== 1'b1 && n < 500) begin
            @(posedge clock);
            n++;
        end
        check("request taken", 32'h1, 32'(ready));
        if (!shadow.exists(a)) shadow[a] = 32'h0;
        for (int b = 0; b < 4; b++)
            if (wr && !m[b]) shadow[a][8*b+:8] = d[8*b+:8];
        if (!wr) exp_q.push_back(shadow[a]);
    endtask

    task automatic read_all(input int cnt);
        for (int i = 0; i < cnt; i++) acc(1'b0, adr[i], 32'h0, 4'h0);
        @(negedge clock);
        req = 1'b0;
    endtask

    initial forever begin
        @(negedge clock);
        if (rvalid === 1'b1 && exp_q.size() == 0)
            check("rvalid", 32'h0, 32'h1);
        else if (rvalid === 1'b1)
            check("rdata", exp_q.pop_front(), rdata);
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("unexpected run length: expected end seen timeout");
        report_and_stop;
    end

    initial begin
        int n;
        rst_b = 0; req = 0; req_wr = 0; req_bank = 0; req_row = 0;
        req_col = 0; req_wdata = 0; req_mask = 0; sr_req = 0;
        err_count = 0; n_compared = 0; seed = 32'h6f92;
        repeat (20) @(negedge clock);
        rst_b = 1;
        wait_lvl(init_done, 1'b1, "init_done");
        wait_lvl(ready, 1'b1, "ready");
        $display("test init ended");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            adr[i] = {i[1:0], seed[20:0]};
            seed = lfsr(seed);
            acc(1'b1, adr[i], seed, 4'h0);
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            acc(1'b1, adr[i], ~seed, seed[3:0]);
        end
        read_all(8);
        $display("test write and read ended");
        repeat (3 * refi) @(negedge clock);
        read_all(2);
        $display("test idle refresh ended");
        sr_req = 1'b1;
        wait_lvl(in_sr, 1'b1, "in_sr");
        repeat (30) @(negedge clock);
        check("device in self-refresh", 32'h1, 32'(dev_sr));
        check("ready in self-refresh", 32'h0, 32'(ready));
        sr_req = 1'b0;
        wait_lvl(in_sr, 1'b0, "in_sr");
        wait_lvl(ready, 1'b1, "ready");
        check("device in self-refresh", 32'h0, 32'(dev_sr));
        read_all(8);
        $display("test self-refresh ended");
        n = 0;
        while (exp_q.size() != 0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        check("pending reads", 32'h0, 32'(exp_q.size()));
        check("device timing slips", 32'h0, 32'(n_bad));
        report_and_stop;
    end
endmodule
